// *** hdl/flbp_host.sv ***
// The register offsets and strobed register access are this design's own decisions.
`timescale 1ns/1ps
module flbp_host #(
    parameter int         ADDR_W           = 20,
    parameter int         DATA_W           = 16,
    parameter int         BUSY_TIMEOUT_CYC = flbp_pkg::BUSY_TIMEOUT_CYC,
    parameter logic [7:0] CMD_LOCK_SETUP   = 8'h01,
    parameter logic [7:0] CMD_BLOCK_CONF   = 8'h02,
    parameter logic [7:0] CMD_PERM_CONF    = 8'h03,
    parameter logic [7:0] CMD_CLEAR_CONF   = 8'h04,
    parameter logic [7:0] CMD_CLEAR_STATUS = 8'h05
) (
    input  wire logic              sys_clk_i,
    input  wire logic              rst_b_i,
    input  wire logic              ce_i,
    input  wire logic [3:0]        reg_addr_i,
    input  wire logic [31:0]       reg_wdata_i,
    input  wire logic              reg_we_i,
    input  wire logic              reg_re_i,
    output logic [31:0]            reg_rdata_o,
    output logic [ADDR_W-1:0]      flash_addr_o,
    output logic [DATA_W-1:0]      flash_dq_o,
    output logic                   flash_dq_oe_o,
    input  wire logic [DATA_W-1:0] flash_dq_i,
    output logic                   flash_ce_b_o,
    output logic                   flash_we_b_o,
    output logic                   flash_oe_b_o,
    output logic                   reset_powerdown_n_o,
    output logic                   write_protect_b_o,
    input  wire logic              ready_busy_out_i
);
    import flbp_pkg::*;

    if (ADDR_W < 1 || ADDR_W > 32 || DATA_W < 8 || DATA_W > 32 || BUSY_TIMEOUT_CYC < 2)
    begin : g_bad_param
        $error("unsupported width or timeout");
    end

    typedef enum logic [2:0] {
        S_IDLE = 3'b000,
        S_W1   = 3'b001,
        S_W2   = 3'b010,
        S_WAIT = 3'b011,
        S_READ = 3'b100,
        S_CLR  = 3'b101,
        S_FIN  = 3'b110
    } flbp_main_st_type;

    typedef struct packed {
        flbp_main_st_type  st;
        flbp_op_type       op;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
        logic [7:0]        sr;
        logic              done;
        logic              timeout;
        logic              unknown;
        logic [4:0]        err;
        logic              rp;
        logic              prot;
        logic [31:0]       tmo;
        logic              cyc_start;
        logic              cyc_write;
        logic [ADDR_W-1:0] cyc_addr;
        logic [DATA_W-1:0] cyc_data;
        logic [31:0]       rdata;
    } flbp_main_state_type;

    flbp_main_state_type s;
    flbp_main_state_type next_s;

    logic              cyc_done;
    logic [DATA_W-1:0] cyc_rdata;
    logic              sr_ready;
    logic              sr_seq;
    logic              sr_supply;
    logic              sr_prot;
    logic              sr_ws;
    logic              sr_ec;
    logic              sr_any;
    logic              go;
    logic              abort;

    flbp_bus_cycle #(
        .ADDR_W (ADDR_W),
        .DATA_W (DATA_W)
    ) u_cycle (
        .sys_clk_i     (sys_clk_i),
        .rst_b_i       (rst_b_i),
        .ce_i          (ce_i),
        .start_i       (s.cyc_start),
        .write_i       (s.cyc_write),
        .addr_i        (s.cyc_addr),
        .data_i        (s.cyc_data),
        .done_o        (cyc_done),
        .rdata_o       (cyc_rdata),
        .flash_addr_o  (flash_addr_o),
        .flash_dq_o    (flash_dq_o),
        .flash_dq_oe_o (flash_dq_oe_o),
        .flash_dq_i    (flash_dq_i),
        .flash_ce_b_o  (flash_ce_b_o),
        .flash_we_b_o  (flash_we_b_o),
        .flash_oe_b_o  (flash_oe_b_o)
    );

    flbp_sr_decode u_decode (
        .sr_i              (cyc_rdata[7:0]),
        .ready_o           (sr_ready),
        .seq_err_o         (sr_seq),
        .supply_low_o      (sr_supply),
        .protect_o         (sr_prot),
        .write_set_err_o   (sr_ws),
        .erase_clear_err_o (sr_ec),
        .any_err_o         (sr_any)
    );

    // start and abort conditions
    assign go    = reg_we_i & (reg_addr_i == REG_CTRL) & reg_wdata_i[CTRL_GO_POS]
                 & (s.st == S_IDLE);
    assign abort = ~s.rp & (s.st == S_WAIT);

    // order engine, register port and pin controls
    always_comb begin
        next_s           = s;
        next_s.cyc_start = 1'b0;
        next_s.rdata     = 32'h0;
        // address and data writes are refused while an order runs
        if (reg_we_i && s.st == S_IDLE) begin
            if (reg_addr_i == REG_ADDR) begin
                next_s.addr = reg_wdata_i[ADDR_W-1:0];
            end
            if (reg_addr_i == REG_DATA) begin
                next_s.data = reg_wdata_i[DATA_W-1:0];
            end
        end
        // pin bits stay writable so a hung clear can be reset
        if (reg_we_i && reg_addr_i == REG_PINS) begin
            next_s.rp   = reg_wdata_i[PINS_RESET_POS];
            next_s.prot = reg_wdata_i[PINS_PROT_POS];
        end
        unique case (s.st)
            S_IDLE: begin
                if (go) begin
                    next_s.op        = flbp_op_type'(reg_wdata_i[CTRL_OP_LSB +: 3]);
                    next_s.done      = 1'b0;
                    next_s.timeout   = 1'b0;
                    next_s.err       = 5'h0;
                    next_s.st        = S_W1;
                    next_s.cyc_start = 1'b1;
                    next_s.cyc_write = 1'b1;
                    next_s.cyc_addr  = s.addr;
                    unique case (flbp_op_type'(reg_wdata_i[CTRL_OP_LSB +: 3]))
                        OP_OTP_PROGRAM: next_s.cyc_data = DATA_W'(CMD_OTP_PROGRAM);
                        OP_READ_STATUS: next_s.cyc_data = DATA_W'(CMD_READ_STATUS);
                        OP_CLEAR_STAT:  next_s.cyc_data = DATA_W'(CMD_CLEAR_STATUS);
                        default:        next_s.cyc_data = DATA_W'(CMD_LOCK_SETUP);
                    endcase
                end
            end
            S_W1: begin
                if (cyc_done) begin
                    if (s.op == OP_READ_STATUS) begin
                        next_s.st        = S_READ;
                        next_s.cyc_start = 1'b1;
                        next_s.cyc_write = 1'b0;
                    end else if (s.op == OP_CLEAR_STAT) begin
                        next_s.st = S_FIN;
                    end else begin
                        next_s.st        = S_W2;
                        next_s.cyc_start = 1'b1;
                        next_s.cyc_write = 1'b1;
                        next_s.cyc_addr  = s.addr;
                        unique case (s.op)
                            OP_SET_BLOCK:   next_s.cyc_data = DATA_W'(CMD_BLOCK_CONF);
                            OP_SET_PERM:    next_s.cyc_data = DATA_W'(CMD_PERM_CONF);
                            OP_CLEAR_LOCKS: next_s.cyc_data = DATA_W'(CMD_CLEAR_CONF);
                            default:        next_s.cyc_data = s.data;
                        endcase
                    end
                end
            end
            S_W2: begin
                if (cyc_done) begin
                    next_s.st  = S_WAIT;
                    next_s.tmo = 32'h0;
                end
            end
            S_WAIT: begin
                if (abort) begin
                    next_s.st = S_FIN;
                end else if (ready_busy_out_i) begin
                    next_s.st        = S_READ;
                    next_s.cyc_start = 1'b1;
                    next_s.cyc_write = 1'b0;
                end else if (s.tmo == 32'(BUSY_TIMEOUT_CYC - 1)) begin
                    next_s.timeout = 1'b1;
                    next_s.st      = S_FIN;
                end else begin
                    next_s.tmo = s.tmo + 32'h1;
                end
            end
            S_READ: begin
                if (cyc_done) begin
                    next_s.sr  = cyc_rdata[7:0];
                    next_s.err = {sr_ec, sr_ws, sr_prot, sr_supply, sr_seq};
                    if (!sr_ready && s.op != OP_READ_STATUS) begin
                        // ready bit disagrees with the pin, read again
                        next_s.cyc_start = 1'b1;
                        next_s.cyc_write = 1'b0;
                    end else if (sr_any && s.op != OP_READ_STATUS) begin
                        next_s.st        = S_CLR;
                        next_s.cyc_start = 1'b1;
                        next_s.cyc_write = 1'b1;
                        next_s.cyc_data  = DATA_W'(CMD_CLEAR_STATUS);
                    end else begin
                        next_s.st = S_FIN;
                    end
                end
            end
            S_CLR: begin
                if (cyc_done) begin
                    next_s.st = S_FIN;
                end
            end
            S_FIN: begin
                next_s.done = 1'b1;
                next_s.st   = S_IDLE;
            end
            default: begin
                next_s.st = S_IDLE;
            end
        endcase
        if (s.st == S_READ && cyc_done && sr_ready && !sr_any && s.op == OP_CLEAR_LOCKS) begin
            next_s.unknown = 1'b0;
        end
        if (abort && s.op == OP_CLEAR_LOCKS) begin
            next_s.unknown = 1'b1;
        end
        // read data stands only in the cycle after the strobe
        if (reg_re_i) begin
            unique case (reg_addr_i)
                REG_CTRL:   next_s.rdata = {29'h0, s.op};
                REG_ADDR:   next_s.rdata = 32'(s.addr);
                REG_DATA:   next_s.rdata = 32'(s.data);
                REG_STATUS: next_s.rdata = {8'h0, s.sr, 7'h0, s.err, s.unknown, s.timeout,
                                            s.done, (s.st != S_IDLE)};
                REG_PINS:   next_s.rdata = {30'h0, s.prot, s.rp};
                default:    next_s.rdata = 32'h0;
            endcase
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            s      <= '0;
            s.rp   <= PINS_RESET_VAL;
            s.prot <= PINS_PROT_VAL;
        end else if (ce_i) begin
            s <= next_s;
        end
    end

    // pins and read port
    assign reg_rdata_o         = s.rdata;
    assign reset_powerdown_n_o = s.rp;
    assign write_protect_b_o   = s.prot;

    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rst_b_i);

    sequence seq_ready_seen;
        ce_i && s.st == S_WAIT && s.rp && ready_busy_out_i;
    endsequence
    sequence seq_read_started;
        s.st == S_READ && s.cyc_start && !s.cyc_write;
    endsequence

    chk_poll_then_read: assert property (seq_ready_seen |=> seq_read_started)
        else $error("ready pin seen but no status read started");
    chk_read_after_ready: assert property (
        $rose(s.st == S_READ) && $past(s.st) == S_WAIT |-> $past(ready_busy_out_i))
        else $error("status read entered without ready pin");
    chk_clear_on_error: assert property (
        ce_i && s.st == S_READ && cyc_done && sr_ready && sr_any && s.op != OP_READ_STATUS
        |=> s.st == S_CLR && s.cyc_data == DATA_W'(CMD_CLEAR_STATUS))
        else $error("error status not cleared");
    chk_otp_code_first: assert property (
        ce_i && go && reg_wdata_i[CTRL_OP_LSB +: 3] == OP_OTP_PROGRAM
        |=> s.cyc_data == DATA_W'(CMD_OTP_PROGRAM) && s.cyc_start)
        else $error("otp order did not open with otp code");
    chk_otp_second_data: assert property (
        ce_i && s.st == S_W1 && cyc_done && s.op == OP_OTP_PROGRAM
        |=> s.st == S_W2 && s.cyc_data == s.data && s.cyc_addr == s.addr)
        else $error("otp second write lacks address or data");
    chk_status_code: assert property (
        ce_i && go && reg_wdata_i[CTRL_OP_LSB +: 3] == OP_READ_STATUS
        |=> s.cyc_data == DATA_W'(CMD_READ_STATUS))
        else $error("status order did not write status code");
    chk_lock_confirm: assert property (
        ce_i && s.st == S_W1 && cyc_done && s.op == OP_SET_BLOCK
        |=> s.st == S_W2 && s.cyc_data == DATA_W'(CMD_BLOCK_CONF) && s.cyc_addr == s.addr)
        else $error("block lock confirm wrong");
    chk_abort_unknown: assert property (
        ce_i && abort && s.op == OP_CLEAR_LOCKS |=> s.unknown && s.st == S_FIN)
        else $error("aborted clear not marked unknown");
    chk_done_pulse: assert property (
        ce_i && s.st == S_FIN |=> s.done && s.st == S_IDLE)
        else $error("finish did not raise done");
    chk_rdata_slot: assert property (
        ce_i && !reg_re_i |=> reg_rdata_o == 32'h0)
        else $error("read data outside its slot");
endmodule

// *** hdl/flbp_pkg.sv ***
// How it works
// - set lock-bit takes setup then confirm write
// - poll ready, check error, clear status
// - aborted clear leaves bits unknown, repeat
// - otp program is code then address data
// - read status code enters status-read mode
package flbp_pkg;
    // clock and bus-cycle timing
    localparam int CLK_PERIOD_NS   = 100;
    localparam int WE_PULSE_NS     = 100;
    localparam int RD_ACCESS_NS    = 200;
    localparam int BUSY_TIMEOUT_US = 20000;
    // least times round up, the longest wait rounds down
    localparam int WE_PULSE_CYC     = (WE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RD_ACCESS_CYC    = (RD_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int BUSY_TIMEOUT_CYC = (BUSY_TIMEOUT_US * 1000) / CLK_PERIOD_NS;

    // command codes printed for this part
    localparam logic [7:0] CMD_OTP_PROGRAM = 8'hc0;
    localparam logic [7:0] CMD_READ_STATUS = 8'h70;

    // status byte of the device
    localparam int SR_READY_POS       = 7;
    localparam int SR_ERASE_CLEAR_POS = 5;
    localparam int SR_WRITE_SET_POS   = 4;
    localparam int SR_SUPPLY_LOW_POS  = 3;
    localparam int SR_PROTECT_POS     = 1;

    // controller register map, word index
    localparam logic [3:0] REG_CTRL   = 4'h0;
    localparam logic [3:0] REG_ADDR   = 4'h1;
    localparam logic [3:0] REG_DATA   = 4'h2;
    localparam logic [3:0] REG_STATUS = 4'h3;
    localparam logic [3:0] REG_PINS   = 4'h4;

    // field positions
    localparam int CTRL_OP_LSB     = 0;
    localparam int CTRL_GO_POS     = 8;
    localparam int PINS_RESET_POS  = 0;
    localparam int PINS_PROT_POS   = 1;
    localparam int ST_BUSY_POS     = 0;
    localparam int ST_DONE_POS     = 1;
    localparam int ST_TIMEOUT_POS  = 2;
    localparam int ST_UNKNOWN_POS  = 3;
    localparam int ST_SEQ_POS      = 4;
    localparam int ST_SUPPLY_POS   = 5;
    localparam int ST_PROT_POS     = 6;
    localparam int ST_WS_POS       = 7;
    localparam int ST_EC_POS       = 8;
    localparam int ST_SR_LSB       = 16;

    // reset values of the pin control bits
    localparam logic PINS_RESET_VAL = 1'b1;
    localparam logic PINS_PROT_VAL  = 1'b0;

    // operations that software can order
    typedef enum logic [2:0] {
        OP_SET_BLOCK   = 3'b000,
        OP_SET_PERM    = 3'b001,
        OP_CLEAR_LOCKS = 3'b010,
        OP_OTP_PROGRAM = 3'b011,
        OP_READ_STATUS = 3'b100,
        OP_CLEAR_STAT  = 3'b101
    } flbp_op_type;
endpackage

// *** hdl/flbp_sr_decode.sv ***
`timescale 1ns/1ps
module flbp_sr_decode (
    input  wire logic [7:0] sr_i,
    output logic            ready_o,
    output logic            seq_err_o,
    output logic            supply_low_o,
    output logic            protect_o,
    output logic            write_set_err_o,
    output logic            erase_clear_err_o,
    output logic            any_err_o
);
    import flbp_pkg::*;

    // both error bits together mean a malformed sequence
    always_comb begin
        ready_o           = sr_i[SR_READY_POS];
        seq_err_o         = sr_i[SR_WRITE_SET_POS] & sr_i[SR_ERASE_CLEAR_POS];
        supply_low_o      = sr_i[SR_SUPPLY_LOW_POS];
        protect_o         = sr_i[SR_PROTECT_POS];
        write_set_err_o   = sr_i[SR_WRITE_SET_POS] & ~sr_i[SR_ERASE_CLEAR_POS];
        erase_clear_err_o = sr_i[SR_ERASE_CLEAR_POS] & ~sr_i[SR_WRITE_SET_POS];
        // bits 6, 2 and 0 are suspend and spare, masked out
        any_err_o         = sr_i[SR_WRITE_SET_POS] | sr_i[SR_ERASE_CLEAR_POS]
                          | sr_i[SR_SUPPLY_LOW_POS] | sr_i[SR_PROTECT_POS];
    end
endmodule

// *** hdl/flbp_bus_cycle.sv ***
`timescale 1ns/1ps
module flbp_bus_cycle #(
    parameter int ADDR_W = 20,
    parameter int DATA_W = 16
) (
    input  wire logic              sys_clk_i,
    input  wire logic              rst_b_i,
    input  wire logic              ce_i,
    input  wire logic              start_i,
    input  wire logic              write_i,
    input  wire logic [ADDR_W-1:0] addr_i,
    input  wire logic [DATA_W-1:0] data_i,
    output logic                   done_o,
    output logic [DATA_W-1:0]      rdata_o,
    output logic [ADDR_W-1:0]      flash_addr_o,
    output logic [DATA_W-1:0]      flash_dq_o,
    output logic                   flash_dq_oe_o,
    input  wire logic [DATA_W-1:0] flash_dq_i,
    output logic                   flash_ce_b_o,
    output logic                   flash_we_b_o,
    output logic                   flash_oe_b_o
);
    import flbp_pkg::*;

    localparam logic [3:0] WE_LEN = 4'(WE_PULSE_CYC - 1);
    localparam logic [3:0] RD_LEN = 4'(RD_ACCESS_CYC - 1);

    if (WE_PULSE_CYC < 1 || WE_PULSE_CYC > 16 || RD_ACCESS_CYC < 1 || RD_ACCESS_CYC > 16)
    begin : g_bad_timing
        $error("bus cycle lengths must be 1 to 16 clocks");
    end

    typedef enum logic [1:0] {
        PH_IDLE  = 2'b00,
        PH_SETUP = 2'b01,
        PH_PULSE = 2'b10,
        PH_HOLD  = 2'b11
    } flbp_phase_type;

    typedef struct packed {
        flbp_phase_type    ph;
        logic              write;
        logic [3:0]        cnt;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
        logic [DATA_W-1:0] rdata;
        logic              done;
    } flbp_cycle_state_type;

    flbp_cycle_state_type s;
    flbp_cycle_state_type next_s;

    // one strobe per cycle; a start while busy is dropped
    always_comb begin
        next_s      = s;
        next_s.done = 1'b0;
        unique case (s.ph)
            PH_IDLE: begin
                if (start_i) begin
                    next_s.ph    = PH_SETUP;
                    next_s.write = write_i;
                    next_s.addr  = addr_i;
                    next_s.data  = data_i;
                end
            end
            PH_SETUP: begin
                next_s.ph  = PH_PULSE;
                next_s.cnt = s.write ? WE_LEN : RD_LEN;
            end
            PH_PULSE: begin
                if (s.cnt != 4'h0) begin
                    next_s.cnt = s.cnt - 4'h1;
                end else if (s.write) begin
                    next_s.ph = PH_HOLD;
                end else begin
                    next_s.rdata = flash_dq_i;
                    next_s.done  = 1'b1;
                    next_s.ph    = PH_IDLE;
                end
            end
            PH_HOLD: begin
                next_s.done = 1'b1;
                next_s.ph   = PH_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            s <= '0;
        end else if (ce_i) begin
            s <= next_s;
        end
    end

    // strobes decode from phase, address and data from flops
    assign done_o        = s.done;
    assign rdata_o       = s.rdata;
    assign flash_addr_o  = s.addr;
    assign flash_dq_o    = s.data;
    assign flash_dq_oe_o = s.write & (s.ph != PH_IDLE);
    assign flash_ce_b_o  = (s.ph == PH_IDLE);
    assign flash_we_b_o  = ~(s.write & (s.ph == PH_PULSE));
    assign flash_oe_b_o  = ~(~s.write & (s.ph == PH_PULSE));
endmodule

// *** test/flbp_dev_model.sv ***
`timescale 1ns/1ps
module flbp_dev_model (
    input  wire logic [19:0] addr_i,
    input  wire logic [15:0] dq_i,
    output logic [15:0]      dq_o,
    input  wire logic        ce_b_i,
    input  wire logic        we_b_i,
    input  wire logic        oe_b_i,
    input  wire logic        rst_n_i,
    input  wire logic        supply_ok_i,
    input  wire logic        otp_lock_i,
    input  wire logic        wp_b_i,
    output logic             ready_o
);
    logic [7:0] sr = 8'h80;
    logic [3:0] lock = 4'h0;
    logic       perm = 1'b0;
    logic       clr = 1'b0;
    logic [1:0] pend = 2'd0;
    // top two blocks also need the pin high
    wire logic [3:0] array_open = ~lock & {{2{wp_b_i}}, 2'b11} & {4{supply_ok_i & rst_n_i}};
    initial ready_o = 1'b1;
    // reads give status; released bus flips
    assign dq_o = (!ce_b_i && !oe_b_i) ? {8'h00, sr} : {8'hff, ~sr};
    task automatic fin(input logic [7:0] err);
        ready_o = 1'b0;
        sr[7] = 1'b0;
        // ends off the clock edge so the pin never races the sampler
        #1030;
        if (!ready_o) sr = sr | err;
        sr[7] = 1'b1;
        ready_o = 1'b1;
    endtask
    always @(negedge rst_n_i) begin
        pend = 2'd0;
        if (!ready_o && clr) lock = 4'bxxxx;
        sr[7] = 1'b1;
        ready_o = 1'b1;
    end
    // taken at end of write strobe
    always @(posedge we_b_i) begin
        if (!ce_b_i && rst_n_i) begin
            if (pend == 2'd2) begin
                pend = 2'd0;
                fin(!supply_ok_i ? 8'h18 : otp_lock_i ? 8'h12 : 8'h00);
            end else if (pend == 2'd1) begin
                pend = 2'd0;
                case (dq_i[7:0])
                    8'h02: begin
                        if (supply_ok_i && !perm) lock[addr_i[19:18]] = 1'b1;
                        fin(!supply_ok_i ? 8'h18 : perm ? 8'h12 : 8'h00);
                    end
                    8'h03: begin
                        perm = perm | supply_ok_i;
                        fin(supply_ok_i ? 8'h00 : 8'h18);
                    end
                    8'h04: begin
                        clr = 1'b1;
                        if (supply_ok_i && !perm) lock = 4'h0;
                        fin(!supply_ok_i ? 8'h28 : perm ? 8'h22 : 8'h00);
                        clr = 1'b0;
                    end
                    default: fin(8'h30);
                endcase
            end else if (dq_i[7:0] == 8'h05) sr[5:1] = 5'h00;
            else if (dq_i[7:0] == 8'h01) pend = 2'd1;
            else if (dq_i[7:0] == 8'hc0) pend = 2'd2;
        end
    end
endmodule

// *** test/tb_flbp_host.sv ***
`timescale 1ns/1ps
module tb_flbp_host;
    import flbp_pkg::*;
    logic        clk = 1'b0;
    logic        rst_b = 1'b0;
    logic        we = 1'b0;
    logic        re = 1'b0;
    logic        sup = 1'b1;
    logic        otpl = 1'b0;
    logic [3:0]  ra = 4'h0;
    logic [31:0] wd = 32'h0;
    logic [31:0] rdata, s;
    logic [19:0] fa;
    logic [15:0] hdq, ddq;
    logic        dq_oe, ce_b, we_b, oe_b, rp_n, wp_b, rb;
    int          failures = 0;
    int          cmp_count = 0;
    // shared data line: host wins while enabled
    wire logic [15:0] dq = dq_oe ? hdq : ddq;
    flbp_host #(.BUSY_TIMEOUT_CYC(50)) u_flbp_host (.sys_clk_i(clk), .rst_b_i(rst_b),
        .ce_i(1'b1), .reg_addr_i(ra), .reg_wdata_i(wd), .reg_we_i(we), .reg_re_i(re),
        .reg_rdata_o(rdata), .flash_addr_o(fa), .flash_dq_o(hdq), .flash_dq_oe_o(dq_oe),
        .flash_dq_i(dq), .flash_ce_b_o(ce_b), .flash_we_b_o(we_b), .flash_oe_b_o(oe_b),
        .reset_powerdown_n_o(rp_n), .write_protect_b_o(wp_b), .ready_busy_out_i(rb));
    flbp_dev_model u_flbp_dev_model (.addr_i(fa), .dq_i(dq), .dq_o(ddq), .ce_b_i(ce_b),
        .we_b_i(we_b), .oe_b_i(oe_b), .rst_n_i(rp_n), .supply_ok_i(sup),
        .otp_lock_i(otpl), .wp_b_i(wp_b), .ready_o(rb));
    always #50 clk = ~clk;
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        ra <= a;
        wd <= d;
        we <= 1'b1;
        @(posedge clk);
        we <= 1'b0;
    endtask
    // read data stands only in the cycle after the strobe
    task automatic rd(input logic [3:0] a);
        @(posedge clk);
        ra <= a;
        re <= 1'b1;
        @(posedge clk);
        re <= 1'b0;
        #1 s = rdata;
    endtask
    task automatic poll;
        s = 32'h0;
        for (int n = 0; n < 100 && s[ST_DONE_POS] !== 1'b1; n++) rd(REG_STATUS);
    endtask
    // done, status byte and flags decoded from it
    task automatic op(input flbp_op_type o, input logic [7:0] b);
        wr(REG_CTRL, {23'h0, 1'b1, 5'h0, o});
        poll;
        check(s & 32'h00ff01f2, {8'h0, b, 7'h0, b[5] & !b[4], b[4] & !b[5], b[1], b[3],
            b[4] & b[5], 4'h2});
    endtask
    task automatic pins_map;
        rd(REG_PINS);
        check(s, 32'h1);
        rd(4'hf);
        check(s, 32'h0);
        wr(REG_PINS, 32'h3);
        @(posedge clk);
        #1 check({30'h0, wp_b, rp_n}, 32'h3);
    endtask
    task automatic lock_ops;
        wr(REG_PINS, 32'h1);
        wr(REG_ADDR, 32'h40000);
        op(OP_SET_BLOCK, 8'h80);
        check({31'h0, u_flbp_dev_model.lock[1]}, 32'h1);
        check({28'h0, u_flbp_dev_model.array_open}, 32'h1);
        wr(REG_PINS, 32'h3);
        op(OP_READ_STATUS, 8'h80);
        check({28'h0, u_flbp_dev_model.array_open}, 32'hd);
        op(OP_CLEAR_LOCKS, 8'h80);
        check({28'h0, u_flbp_dev_model.lock}, 32'h0);
        check({28'h0, u_flbp_dev_model.array_open}, 32'hf);
    endtask
    task automatic low_supply;
        sup <= 1'b0;
        op(OP_CLEAR_LOCKS, 8'ha8);
        op(OP_SET_BLOCK, 8'h98);
        wr(REG_DATA, 32'h5a5a);
        op(OP_OTP_PROGRAM, 8'h98);
        sup <= 1'b1;
        op(OP_OTP_PROGRAM, 8'h80);
        otpl <= 1'b1;
        op(OP_OTP_PROGRAM, 8'h92);
        otpl <= 1'b0;
    endtask
    // reset pin dropped while the clear runs
    task automatic abort_clear;
        wr(REG_CTRL, 32'h102);
        repeat (10) @(posedge clk);
        wr(REG_PINS, 32'h2);
        poll;
        check({31'h0, s[ST_UNKNOWN_POS]}, 32'h1);
        wr(REG_PINS, 32'h3);
        op(OP_CLEAR_LOCKS, 8'h80);
        check({31'h0, s[ST_UNKNOWN_POS]}, 32'h0);
        check({28'h0, u_flbp_dev_model.lock}, 32'h0);
    endtask
    task automatic perm_ops;
        op(OP_SET_PERM, 8'h80);
        op(OP_SET_BLOCK, 8'h92);
        op(OP_CLEAR_LOCKS, 8'ha2);
        check({31'h0, u_flbp_dev_model.perm}, 32'h1);
        // clear status order: one write, then done
        wr(REG_CTRL, 32'h105);
        poll;
        check(s & 32'h3, 32'h2);
        check({24'h0, u_flbp_dev_model.sr}, 32'h80);
    endtask
    task automatic close_out;
        $display("compares %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    initial begin
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        pins_map;
        lock_ops;
        low_supply;
        abort_clear;
        perm_ops;
        close_out;
    end
    // the whole run needs well under this span
    initial begin
        #2000000;
        failures++;
        close_out;
    end
endmodule
